// [rtl/lpl_top.sv]
// primitive logic library: gates, d flip-flop, two j-k variants
// assumes every input is synchronous to clk_sys_in
//
// How it works
// (R01) nand output low only when all high
// (R02) and output high only when all high
// (R03) inverter gives complement on several outputs
// (R04) d flip-flop copies data on clock rise
// (R05) low preset sets, low clear clears d
// (R06) multi terms and-ed, unconnected counts satisfied
// (R07) single variant: set sets, reset resets
// (R08) master on rise, slave on fall
// (R09) jam inputs unclocked and override terms
// (R10) low preset forces 1, clear forces 0
// (R11) both terms low: state held
// (R12) both terms high: state inverted at fall
// (R13) only set sets, only reset clears
`timescale 1ns/100ps
`default_nettype none

module lpl_top (
   // system
   input  wire logic                         clk_sys_in,
   input  wire logic                         srst_in,
   // negated-and gate
   input  wire logic [lpl_pkg::NAND_W-1:0]   nand_a_in,
   output logic                              nand_y_out,
   // and gate
   input  wire logic [lpl_pkg::AND_W-1:0]    and_a_in,
   output logic                              and_y_out,
   // inverting driver
   input  wire logic                         inv_a_in,
   output logic [lpl_pkg::INV_FANOUT-1:0]    inv_y_out,
   // edge-triggered d flip-flop
   input  wire logic                         dff_clk_in,
   input  wire logic                         dff_d_in,
   input  wire logic                         dff_preset_n_in,
   input  wire logic                         dff_clear_n_in,
   output logic                              dff_q_out,
   output logic                              dff_q_n_out,
   // multi-input j-k flip-flop
   input  wire logic                         jkm_clk_in,
   input  wire logic [lpl_pkg::JKM_W-1:0]    jkm_set_in,
   input  wire logic [lpl_pkg::JKM_W-1:0]    jkm_set_used_in,
   input  wire logic [lpl_pkg::JKM_W-1:0]    jkm_reset_in,
   input  wire logic [lpl_pkg::JKM_W-1:0]    jkm_reset_used_in,
   input  wire logic                         jkm_preset_n_in,
   input  wire logic                         jkm_clear_n_in,
   output logic                              jkm_q_out,
   output logic                              jkm_q_n_out,
   // single-input j-k flip-flop
   input  wire logic                         jks_clk_in,
   input  wire logic                         jks_set_in,
   input  wire logic                         jks_reset_in,
   input  wire logic                         jks_clear_n_in,
   output logic                              jks_q_out,
   output logic                              jks_q_n_out
);

   // ****************************************
   // gates
   // ****************************************
   // gates are registered so every output
   // comes from a flip-flop; this costs one
   // cycle of latency against the real gate

   // negated-and gate
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         nand_y_out <= lpl_pkg::QN_RST;
      end else begin
         nand_y_out <= ~(&nand_a_in);  // R01
      end
   end

   // and gate
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         and_y_out <= lpl_pkg::Q_RST;
      end else begin
         and_y_out <= &and_a_in;  // R02
      end
   end

   // inverting driver, one flop per copy
   // separate copies keep load off any one net
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         inv_y_out <= '0;
      end else begin
         inv_y_out <= {lpl_pkg::INV_FANOUT{~inv_a_in}};  // R03
      end
   end

   // ****************************************
   // edge-triggered d flip-flop
   // ****************************************
   logic dff_clk_prev;  // element clock, one cycle back
   logic dff_rise;      // element clock rising
   logic dff_jam;       // either jam low

   assign dff_rise = dff_clk_in & ~dff_clk_prev;
   assign dff_jam  = ~dff_preset_n_in | ~dff_clear_n_in;

   // element clock history
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         dff_clk_prev <= 1'h0;
      end else begin
         dff_clk_prev <= dff_clk_in;
      end
   end

   // state pair
   // jam acts whatever the element clock does;
   // both jams low drive both outputs high
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         dff_q_out   <= lpl_pkg::Q_RST;
         dff_q_n_out <= lpl_pkg::QN_RST;
      end else if (dff_jam) begin
         // jam path
         dff_q_out   <= ~dff_preset_n_in;  // R05
         dff_q_n_out <= ~dff_clear_n_in;   // R05
      end else if (dff_rise) begin
         // clocked path
         dff_q_out   <= dff_d_in;   // R04
         dff_q_n_out <= ~dff_d_in;  // R04
      end
   end

   // ****************************************
   // j-k flip-flops
   // ****************************************

   // multi-input variant, with preset
   lpl_jk #(
      .W          (lpl_pkg::JKM_W),
      .HAS_PRESET (1'b1)
   ) u_jk_multi (
      .clk_in        (clk_sys_in),
      .srst_in       (srst_in),
      .el_clk_in     (jkm_clk_in),
      .set_in        (jkm_set_in),
      .set_used_in   (jkm_set_used_in),
      .reset_in      (jkm_reset_in),
      .reset_used_in (jkm_reset_used_in),
      .preset_n_in   (jkm_preset_n_in),
      .clear_n_in    (jkm_clear_n_in),
      .q_out         (jkm_q_out),
      .q_n_out       (jkm_q_n_out)
   );

   // single-input variant, clear only;
   // its one term always counts as connected
   lpl_jk #(
      .W          (lpl_pkg::JKS_W),
      .HAS_PRESET (1'b0)
   ) u_jk_single (
      .clk_in        (clk_sys_in),
      .srst_in       (srst_in),
      .el_clk_in     (jks_clk_in),
      .set_in        (jks_set_in),
      .set_used_in   (1'h1),
      .reset_in      (jks_reset_in),
      .reset_used_in (1'h1),
      .preset_n_in   (1'h1),
      .clear_n_in    (jks_clear_n_in),
      .q_out         (jks_q_out),
      .q_n_out       (jks_q_n_out)
   );

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (srst_in);

   // nand: low exactly when all inputs high
   property p_r01_nand;
      !$past(srst_in) |-> nand_y_out == !(&$past(nand_a_in));
   endproperty
   a_r01_nand: assert property (p_r01_nand) else $error("nand output wrong"); // R01

   // and: high exactly when all inputs high
   property p_r02_and;
      !$past(srst_in) |-> and_y_out == (&$past(and_a_in));
   endproperty
   a_r02_and: assert property (p_r02_and) else $error("and output wrong"); // R02

   // inverter: every copy is the complement
   property p_r03_inv;
      !$past(srst_in) |-> inv_y_out == {lpl_pkg::INV_FANOUT{!$past(inv_a_in)}};
   endproperty
   a_r03_inv: assert property (p_r03_inv) else $error("inverter copy wrong"); // R03

   // d: data taken on element rise
   sequence s_dff_take;
      dff_rise && !dff_jam;
   endsequence

   property p_r04_capture;
      s_dff_take |=> dff_q_out == $past(dff_d_in) && dff_q_n_out != dff_q_out;
   endproperty
   a_r04_capture: assert property (p_r04_capture) else $error("d not captured"); // R04

   // d: state holds without edge or jam
   property p_r04_hold;
      !dff_rise && !dff_jam |=> $stable(dff_q_out);
   endproperty
   a_r04_hold: assert property (p_r04_hold) else $error("d moved without edge"); // R04

   // d: clear forces 0 at once
   property p_r05_clear;
      !dff_clear_n_in && dff_preset_n_in |=> !dff_q_out && dff_q_n_out;
   endproperty
   a_r05_clear: assert property (p_r05_clear) else $error("d clear failed"); // R05

   // d: preset forces 1 at once
   property p_r05_preset;
      !dff_preset_n_in && dff_clear_n_in |=> dff_q_out && !dff_q_n_out;
   endproperty
   a_r05_preset: assert property (p_r05_preset) else $error("d preset failed"); // R05

   // d: both jams low drive both outputs high
   property p_r05_both;
      !dff_preset_n_in && !dff_clear_n_in |=> dff_q_out && dff_q_n_out;
   endproperty
   a_r05_both: assert property (p_r05_both) else $error("d double jam wrong"); // R05

   // d: complement holds too without edge or jam
   property p_r04_hold_n;
      !dff_rise && !dff_jam |=> $stable(dff_q_n_out);
   endproperty
   a_r04_hold_n: assert property (p_r04_hold_n) else $error("d complement moved"); // R04

   // ****************************************
   // checks on the j-k outputs
   // ****************************************
   // these watch the element pins only, so they
   // stay valid whatever the inner stages do

   // multi j-k: clear forces 0, whatever preset does
   property p_r10_jkm_clear;
      !jkm_clear_n_in |=> !jkm_q_out && jkm_q_n_out;
   endproperty
   a_r10_jkm_clear: assert property (p_r10_jkm_clear) else $error("multi clear did not force 0"); // R10

   // multi j-k: preset alone forces 1
   property p_r10_jkm_preset;
      !jkm_preset_n_in && jkm_clear_n_in |=> jkm_q_out && !jkm_q_n_out;
   endproperty
   a_r10_jkm_preset: assert property (p_r10_jkm_preset) else $error("multi preset did not force 1"); // R10

   // single j-k: clear forces 0
   property p_r10_jks_clear;
      !jks_clear_n_in |=> !jks_q_out && jks_q_n_out;
   endproperty
   a_r10_jks_clear: assert property (p_r10_jks_clear) else $error("single clear did not force 0"); // R10

   // j-k pairs stay complementary at all times
   property p_r08_jkm_pair;
      jkm_q_n_out != jkm_q_out;
   endproperty
   a_r08_jkm_pair: assert property (p_r08_jkm_pair) else $error("multi pair not complementary"); // R08

   property p_r08_jks_pair;
      jks_q_n_out != jks_q_out;
   endproperty
   a_r08_jks_pair: assert property (p_r08_jks_pair) else $error("single pair not complementary"); // R08

   // j-k outputs move only after a fall or a jam
   property p_r08_jkm_quiet;
      !$fell(jkm_clk_in) && jkm_preset_n_in && jkm_clear_n_in |=> $stable(jkm_q_out);
   endproperty
   a_r08_jkm_quiet: assert property (p_r08_jkm_quiet) else $error("multi output moved without fall"); // R08

   property p_r08_jks_quiet;
      !$fell(jks_clk_in) && jks_clear_n_in |=> $stable(jks_q_out);
   endproperty
   a_r08_jks_quiet: assert property (p_r08_jks_quiet) else $error("single output moved without fall"); // R08

   // single j-k, one whole element pulse
   // only a pulse held high four system cycles is
   // matched; other widths are left to the inner checks
   sequence s_jks_rise_set;
      $rose(jks_clk_in) && jks_clear_n_in && jks_set_in && !jks_reset_in;
   endsequence
   sequence s_jks_rise_reset;
      $rose(jks_clk_in) && jks_clear_n_in && !jks_set_in && jks_reset_in;
   endsequence
   sequence s_jks_high;
      (jks_clk_in && jks_clear_n_in)[*3];
   endsequence
   sequence s_jks_fall;
      $fell(jks_clk_in) && jks_clear_n_in;
   endsequence

   // set only: output high after the fall
   property p_r13_jks_set;
      s_jks_rise_set ##1 s_jks_high ##1 s_jks_fall |=> jks_q_out && !jks_q_n_out;
   endproperty
   a_r13_jks_set: assert property (p_r13_jks_set) else $error("single set pulse did not set"); // R13

   property p_r13_jks_reset;
      s_jks_rise_reset ##1 s_jks_high ##1 s_jks_fall |=> !jks_q_out && jks_q_n_out;
   endproperty
   a_r13_jks_reset: assert property (p_r13_jks_reset) else $error("single reset pulse did not clear"); // R13

endmodule

`default_nettype wire

// [include/lpl_pkg.sv]
// shared constants of the primitive logic library
// assumes one system clock; every element is sampled on it
`default_nettype none

package lpl_pkg;

   // ****************************************
   // widths of the gate elements
   // ****************************************
   localparam int unsigned NAND_W     = 4;  // inputs of the negated-and gate
   localparam int unsigned AND_W      = 3;  // inputs of the and gate
   localparam int unsigned INV_FANOUT = 4;  // driven copies of the inverter

   // ****************************************
   // widths of the j-k variants
   // ****************************************
   localparam int unsigned JKM_W = 3;  // terms of the multi-input variant
   localparam int unsigned JKS_W = 1;  // terms of the single-input variant

   // ****************************************
   // reset values
   // ****************************************
   localparam logic Q_RST  = 1'h0;  // state output after reset
   localparam logic QN_RST = 1'h1;  // complement output after reset

   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned SYS_CLK_NS = 100;  // system clock period
   localparam int unsigned GATE_LAT   = 1;    // cycles from gate input to output

endpackage

`default_nettype wire

// [rtl/lpl_jk.sv]
// master-slave j-k flip-flop, one element
// assumes element clock and jam inputs are synchronous to clk_in
`timescale 1ns/100ps
`default_nettype none

module lpl_jk #(
   parameter int unsigned W          = 1,     // terms per input
   parameter bit          HAS_PRESET = 1'b0   // preset jam present
) (
   input  wire logic         clk_in,          // system clock
   input  wire logic         srst_in,         // synchronous reset
   input  wire logic         el_clk_in,       // element clock level
   input  wire logic [W-1:0] set_in,          // set terms
   input  wire logic [W-1:0] set_used_in,     // set terms connected
   input  wire logic [W-1:0] reset_in,        // reset terms
   input  wire logic [W-1:0] reset_used_in,   // reset terms connected
   input  wire logic         preset_n_in,     // preset jam, low active
   input  wire logic         clear_n_in,      // clear jam, low active
   output logic              q_out,           // state output
   output logic              q_n_out          // complement output
);

   // ****************************************
   // edge and term decode
   // ****************************************
   logic el_prev;     // element clock, one cycle back
   logic master;      // master stage
   logic rise;        // element clock rising
   logic fall;        // element clock falling
   logic j_ok;        // set term satisfied
   logic k_ok;        // reset term satisfied
   logic preset_act;  // preset jam active
   logic clear_act;   // clear jam active
   logic jam;         // any jam active

   // unconnected terms count as satisfied
   assign j_ok       = &(set_in | ~set_used_in);   // R06
   assign k_ok       = &(reset_in | ~reset_used_in); // R06
   assign rise       = el_clk_in & ~el_prev;
   assign fall       = ~el_clk_in & el_prev;
   assign preset_act = HAS_PRESET & ~preset_n_in;
   assign clear_act  = ~clear_n_in;
   assign jam        = preset_act | clear_act;

   // element clock history
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         el_prev <= 1'h0;
      end else begin
         el_prev <= el_clk_in;
      end
   end

   // master stage: takes the terms on the rising edge
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         master <= lpl_pkg::Q_RST;
      end else if (jam) begin
         master <= ~clear_act;  // R09 R10
      end else if (rise) begin  // R08
         case ({j_ok, k_ok})
            2'h0:    master <= q_out;   // R11
            2'h1:    master <= 1'h0;    // R07 R13
            2'h2:    master <= 1'h1;    // R07 R13
            2'h3:    master <= ~q_out;  // R12
            default: master <= q_out;
         endcase
      end
   end

   // slave stage: shows the master on the falling edge
   // clear beats preset when both are low, unlike the real part
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         q_out   <= lpl_pkg::Q_RST;
         q_n_out <= lpl_pkg::QN_RST;
      end else if (jam) begin
         q_out   <= ~clear_act;  // R09 R10
         q_n_out <= clear_act;
      end else if (fall) begin
         q_out   <= master;      // R08
         q_n_out <= ~master;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   sequence s_take_clean;
      rise && !jam;
   endsequence
   sequence s_fall_clean;
      fall && !jam;
   endsequence

   property p_r06_open_terms;
      s_take_clean and (&(set_in | ~set_used_in)) && !k_ok |=> master;
   endproperty
   a_r06_open_terms: assert property (p_r06_open_terms) else $error("open set terms not satisfied"); // R06

   property p_r07_single;
      (W == 1) && rise && !jam && (set_in[0] != reset_in[0]) |=> master == $past(set_in[0]);
   endproperty
   a_r07_single: assert property (p_r07_single) else $error("single input did not steer"); // R07

   property p_r08_slave;
      s_fall_clean |=> q_out == $past(master) && q_n_out != q_out;
   endproperty
   a_r08_slave: assert property (p_r08_slave) else $error("slave missed master"); // R08

   property p_r08_hold;
      !rise && !jam |=> $stable(master);
   endproperty
   a_r08_hold: assert property (p_r08_hold) else $error("master moved without edge"); // R08

   property p_r09_priority;
      jam && rise |=> master == !$past(clear_act) && q_out == master;
   endproperty
   a_r09_priority: assert property (p_r09_priority) else $error("clocked terms beat jam"); // R09

   property p_r10_clear;
      clear_act |=> !q_out && q_n_out;
   endproperty
   a_r10_clear: assert property (p_r10_clear) else $error("clear did not force 0"); // R10

   property p_r10_preset;
      preset_act && !clear_act |=> q_out ##1 (q_out || $past(clear_act));
   endproperty
   a_r10_preset: assert property (p_r10_preset) else $error("preset did not force 1"); // R10

   property p_r11_hold;
      s_take_clean and !j_ok && !k_ok |=> master == $past(q_out);
   endproperty
   a_r11_hold: assert property (p_r11_hold) else $error("hold case changed state"); // R11

   property p_r12_toggle;
      s_take_clean and j_ok && k_ok |=> master != $past(q_out);
   endproperty
   a_r12_toggle: assert property (p_r12_toggle) else $error("toggle case did not invert"); // R12

   property p_r13_set;
      s_take_clean and j_ok && !k_ok |=> master;
   endproperty
   a_r13_set: assert property (p_r13_set) else $error("set term did not set"); // R13

   property p_r13_clear;
      s_take_clean and !j_ok && k_ok |=> !master;
   endproperty
   a_r13_clear: assert property (p_r13_clear) else $error("reset term did not clear"); // R13

endmodule

`default_nettype wire

// [tb/lpl_tb.sv]
// testbench of the primitive logic library top
// assumes lpl_pkg is compiled first; no partner model
`timescale 1ns/100ps
`default_nettype none

module testbench;

   // ****************************************
   // signals
   // ****************************************
   logic                       clk_sys_in = 1'b0;  // system clock
   logic                       srst_in    = 1'b1;  // reset at start
   logic [lpl_pkg::NAND_W-1:0] nand_a     = '0;
   logic [lpl_pkg::AND_W-1:0]  and_a      = '0;
   logic                       inv_a      = 1'b0;
   logic                       dff_clk    = 1'b0;  // element clocks idle low
   logic                       dff_d      = 1'b0;
   logic                       dff_pre_n  = 1'b1;  // jams idle high
   logic                       dff_clr_n  = 1'b1;
   logic                       jkm_clk    = 1'b0;
   logic [lpl_pkg::JKM_W-1:0]  jkm_s      = '0;
   logic [lpl_pkg::JKM_W-1:0]  jkm_su     = '1;
   logic [lpl_pkg::JKM_W-1:0]  jkm_r      = '0;
   logic [lpl_pkg::JKM_W-1:0]  jkm_ru     = '1;
   logic                       jkm_pre_n  = 1'b1;
   logic                       jkm_clr_n  = 1'b1;
   logic                       jks_clk    = 1'b0;
   logic                       jks_s      = 1'b0;
   logic                       jks_r      = 1'b0;
   logic                       jks_clr_n  = 1'b1;
   logic                       nand_y;
   logic                       and_y;
   logic [lpl_pkg::INV_FANOUT-1:0] inv_y;
   logic                       dff_q, dff_qn, jkm_q, jkm_qn, jks_q, jks_qn;
   int                         mismatches = 0;     // failed compares
   int                         checks     = 0;     // all compares

   // multi-input table: set, set used, reset, reset used, q after
   localparam logic [2:0] M_S[5]  = '{3'h7, 3'h3, 3'h1, 3'h0, 3'h6};
   localparam logic [2:0] M_SU[5] = '{3'h7, 3'h7, 3'h1, 3'h0, 3'h7};
   localparam logic [2:0] M_R[5]  = '{3'h0, 3'h6, 3'h2, 3'h0, 3'h7};
   localparam logic [2:0] M_RU[5] = '{3'h7, 3'h7, 3'h2, 3'h0, 3'h7};
   localparam logic       M_Q[5]  = '{1'h1, 1'h1, 1'h0, 1'h1, 1'h0};
   // single-input table: set, reset, q after
   localparam logic       S_S[5]  = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
   localparam logic       S_R[5]  = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1};
   localparam logic       S_Q[5]  = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1};

   lpl_top i_dut (
      .clk_sys_in(clk_sys_in), .srst_in(srst_in),
      .nand_a_in(nand_a), .nand_y_out(nand_y),
      .and_a_in(and_a), .and_y_out(and_y),
      .inv_a_in(inv_a), .inv_y_out(inv_y),
      .dff_clk_in(dff_clk), .dff_d_in(dff_d),
      .dff_preset_n_in(dff_pre_n), .dff_clear_n_in(dff_clr_n),
      .dff_q_out(dff_q), .dff_q_n_out(dff_qn),
      .jkm_clk_in(jkm_clk), .jkm_set_in(jkm_s), .jkm_set_used_in(jkm_su),
      .jkm_reset_in(jkm_r), .jkm_reset_used_in(jkm_ru),
      .jkm_preset_n_in(jkm_pre_n), .jkm_clear_n_in(jkm_clr_n),
      .jkm_q_out(jkm_q), .jkm_q_n_out(jkm_qn),
      .jks_clk_in(jks_clk), .jks_set_in(jks_s), .jks_reset_in(jks_r),
      .jks_clear_n_in(jks_clr_n), .jks_q_out(jks_q), .jks_q_n_out(jks_qn)
   );

   // ****************************************
   // helpers
   // ****************************************
   // 100 ns system clock
   initial begin
      forever #50 clk_sys_in = ~clk_sys_in;
   end

   task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // wait edges, then sample 10 ns after the last edge where outputs are settled
   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys_in);
      #10;
   endtask

   // element clock pulse; j-k outputs must not move before the fall
   task automatic pulse(input int sel, input logic q_old);
      @(posedge clk_sys_in);
      case (sel)
         0: dff_clk <= 1'b1;
         1: jkm_clk <= 1'b1;
         default: jks_clk <= 1'b1;
      endcase
      settle(3);
      if (sel == 1) check("jkm before fall", 4'(jkm_q), 4'(q_old));
      if (sel == 2) check("jks before fall", 4'(jks_q), 4'(q_old));
      @(posedge clk_sys_in);
      dff_clk <= 1'b0;
      jkm_clk <= 1'b0;
      jks_clk <= 1'b0;
      settle(3);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   // every input pattern of the three gates
   task automatic test_gates();
      logic [3:0] v;
      for (int i = 0; i < 16; i++) begin
         v = i[3:0];
         @(posedge clk_sys_in);
         nand_a <= v;
         and_a  <= v[2:0];
         inv_a  <= v[0];
         settle(2);
         check("nand", 4'(nand_y), 4'(~&v));
         check("and", 4'(and_y), 4'(&v[2:0]));
         check("inv", inv_y, {4{~v[0]}});
      end
      $display("test gates done");
   endtask

   // copy on rise only; jams win and block the clock
   task automatic test_dff();
      @(posedge clk_sys_in);
      dff_d <= 1'b1;
      pulse(0, 1'b0);
      check("dff rise", 4'({dff_q, dff_qn}), 4'h2);
      @(posedge clk_sys_in);
      dff_d <= 1'b0;
      settle(3);
      check("dff no rise", 4'({dff_q, dff_qn}), 4'h2);
      pulse(0, 1'b1);
      check("dff rise low", 4'({dff_q, dff_qn}), 4'h1);
      @(posedge clk_sys_in);
      dff_pre_n <= 1'b0;
      settle(2);
      check("dff preset", 4'({dff_q, dff_qn}), 4'h2);
      @(posedge clk_sys_in);
      dff_pre_n <= 1'b1;
      dff_clr_n <= 1'b0;
      dff_d     <= 1'b1;
      settle(2);
      check("dff clear", 4'({dff_q, dff_qn}), 4'h1);
      pulse(0, 1'b0);
      check("dff rise in jam", 4'({dff_q, dff_qn}), 4'h1);
      @(posedge clk_sys_in);
      dff_pre_n <= 1'b0;
      settle(2);
      check("dff both jams", 4'({dff_q, dff_qn}), 4'h3);
      @(posedge clk_sys_in);
      dff_pre_n <= 1'b1;
      dff_clr_n <= 1'b1;
      $display("test dff done");
   endtask

   // truth table with partly connected terms, then the jams
   task automatic test_jkm();
      logic q;
      q = 1'b0;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_sys_in);
         jkm_s  <= M_S[i];
         jkm_su <= M_SU[i];
         jkm_r  <= M_R[i];
         jkm_ru <= M_RU[i];
         pulse(1, q);
         q = M_Q[i];
         check("jkm table", 4'({jkm_q, jkm_qn}), 4'({q, ~q}));
      end
      @(posedge clk_sys_in);
      jkm_pre_n <= 1'b0;
      settle(2);
      check("jkm preset", 4'({jkm_q, jkm_qn}), 4'h2);
      @(posedge clk_sys_in);
      jkm_clr_n <= 1'b0;
      settle(2);
      check("jkm both jams", 4'({jkm_q, jkm_qn}), 4'h1);
      @(posedge clk_sys_in);
      jkm_pre_n <= 1'b1;
      jkm_s     <= 3'h7;
      jkm_r     <= 3'h0;
      pulse(1, 1'b0);
      check("jkm clock in jam", 4'({jkm_q, jkm_qn}), 4'h1);
      @(posedge clk_sys_in);
      jkm_clr_n <= 1'b1;
      $display("test jkm done");
   endtask

   // single terms: set, hold, toggle, reset, clear jam
   task automatic test_jks();
      logic q;
      q = 1'b0;
      for (int i = 0; i < 5; i++) begin
         @(posedge clk_sys_in);
         jks_s <= S_S[i];
         jks_r <= S_R[i];
         pulse(2, q);
         q = S_Q[i];
         check("jks table", 4'({jks_q, jks_qn}), 4'({q, ~q}));
      end
      @(posedge clk_sys_in);
      jks_clr_n <= 1'b0;
      jks_s     <= 1'b1;
      jks_r     <= 1'b0;
      settle(2);
      check("jks clear", 4'({jks_q, jks_qn}), 4'h1);
      pulse(2, 1'b0);
      check("jks clock in jam", 4'({jks_q, jks_qn}), 4'h1);
      $display("test jks done");
   endtask

   // ****************************************
   // verdict and sequence
   // ****************************************
   task automatic print_verdict();
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // whole run is a few hundred cycles; cut off far beyond that
   initial begin
      #200000;
      mismatches++;
      $display("wrong value watchdog expected done seen hang");
      print_verdict();
   end

   // reset values are looked at while reset still holds
   initial begin
      settle(3);
      check("reset gates", {nand_y, and_y, inv_y[1:0]}, 4'h8);
      check("reset q", {dff_q, jkm_q, jks_q, dff_qn}, 4'h1);
      check("reset q n", {jkm_qn, jks_qn, inv_y[3:2]}, 4'hc);
      @(posedge clk_sys_in);
      srst_in <= 1'b0;
      $display("test reset done");
      test_gates();
      test_dff();
      test_jkm();
      test_jks();
      print_verdict();
   end

endmodule

`default_nettype wire
